// [verilog/agc_defs.vh]
// Register offsets, reset values and timing constants for the gain control block
`ifndef AGC_DEFS_VH
`define AGC_DEFS_VH
// Byte addresses of the registers
`define A_IF_ATTENUATION_SETTING     8'h00
`define A_CORR      8'h04
`define A_PMF       8'h08
`define A_THR       8'h0c
`define A_HYS       8'h10
`define A_DGC       8'h14
`define A_TIMING    8'h18
`define A_ADCSEL    8'h1c
`define A_STATUS    8'h20
`define A_RESH      8'h24
`define A_RESL      8'h28
`define A_LEVEL     8'h2c
// Reset values (thresholds in 0.1 dB steps)
`define RST_THOFFS  10'h27f
`define RST_TLO     10'h080
`define RST_TUP     10'h100
`define RST_HYS     10'h0d5
`define RST_SLOPE   8'h10
`define RST_UPSH    4'h4
`define RST_DNSH    4'h4
`define RST_DGC_MID 8'h00
`define RST_DGC_MIN 8'h00
// Converter input select codes
`define SEL_STRENGTH 3'h0
`define SEL_TEMP     3'h1
`define SEL_SUPPLY   3'h2
// Gain steps
`define GAIN_MAX    2'h0
`define GAIN_MID    2'h1
`define GAIN_MIN    2'h2
// Timing modes
`define TM_ALWAYS   2'h0
`define TM_START    2'h1
`define TM_FREEZE   2'h2
// Times: clock in kHz, sample rate in kHz, start-up in us
`define CLK_KHZ     200000
`define SAMPLE_KHZ  274
`define STARTUP_US  100
// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// [verilog/strength_delog_table.v]
// Small delog lookup memory indexed by the integrator error, registered read data
`timescale 1ns/1ps
module strength_delog_table #(
  parameter AW = 6,
  parameter DW = 12
) (
  input  wire          aclk,
  input  wire [AW-1:0] addr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  integer v;

  // Exponential-ish contents built once: each step doubles every eight entries
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      v = (({{(DW-1){1'b0}}, 1'b1} << (i / 8)) * (8 + (i % 8))) >> 3;
      mem[i] = v[DW-1:0];
    end
  end

  // Registered read keeps the table output off the combinational path
  always @(posedge aclk) begin
    rdata <= mem[addr];
  end
endmodule // strength_delog_table

// [verilog/rssi_agc_and_adc_mux.v]
// Signal-strength correction, peak-memory AGC, gain stepping and converter mux with AXI4-Lite registers
//
// What this block does
// - 4-bit first IF buffer attenuation setting, 0 to -12 dB, narrower in single mode.
// - Second IF gain takes exactly one of three steps chosen by comparators.
// - Strength value gets programmable offset added and programmable slope applied first.
// - Peak-memory integrator uses attack coefficient rising, decay coefficient falling.
// - Two hysteretic comparators against low and upper attack thresholds.
// - Shared hysteresis; release below threshold minus hysteresis.
// - Comparator states drive analog gain step and matching digital gain correction.
// - Integrator error signal indexes the delog table.
// - Thresholds are offset plus low or upper setting; defaults 63.9, 12.8, 25.6 dB.
// - Gain returns to maximum below low threshold minus hysteresis, default 21.3 dB.
// - Integrator updates at fixed 274 kHz sample rate, adding coefficient times error.
// - Start and freeze timing programmable in one shared timing register, mode plus length.
// - Modes: always active, or timed start or freeze at signal identification.
// - Mux code 000 strength, 001 temperature, 010 half supply; resets to strength.
// - Non-strength select in sleep enables references; results valid after 100 us.
// - End-of-conversion status bit set when a conversion completes with the references ready.
`timescale 1ns/1ps
`include "agc_defs.vh"
module rssi_agc_and_adc_mux #(
  parameter DW          = 10,
  parameter STARTUP_CYC = (`STARTUP_US * `CLK_KHZ + 999) / 1000
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [DW-1:0] adc_data,
  input  wire        adc_done,
  input  wire        sleep_mode,
  input  wire        signal_ident,
  output reg  [3:0]  if_attenuation_setting,
  output reg  [1:0]  second_if_gain,
  output reg  [7:0]  digital_gain_correction,
  output reg  [2:0]  converter_input_select,
  output reg         converter_ref_enable,
  output reg  [11:0] delog_value
);
  localparam integer SAMPLE_DIV = `CLK_KHZ / `SAMPLE_KHZ;
  localparam integer LW = DW + 8;

  // Software-written configuration
  reg [3:0]  if_attenuation_setting_reg;
  reg        ddc_reg;
  reg [9:0]  offs_reg;
  reg [7:0]  slope_reg;
  reg [3:0]  upsh_reg;
  reg [3:0]  dnsh_reg;
  reg [9:0]  thoffs_reg;
  reg [9:0]  tlo_reg;
  reg [9:0]  tup_reg;
  reg [9:0]  hys_reg;
  reg [7:0]  dgc_mid_reg;
  reg [7:0]  dgc_min_reg;
  reg [1:0]  tmode_reg;
  reg [15:0] tlen_reg;
  reg [2:0]  sel_reg;
  // Block state
  reg [LW-1:0] level_reg;
  reg        cmp_lo_reg;
  reg        cmp_up_reg;
  reg        active_reg;
  reg [15:0] tcnt_reg;
  reg [9:0]  div_reg;
  reg        eoc_reg;
  reg [DW-1:0] result_reg;
  reg [15:0] warm_reg;
  reg        ref_ready_reg;
  reg        aw_seen_reg;
  reg        w_seen_reg;
  reg [7:0]  awaddr_reg;
  reg [31:0] wdata_reg;

  wire sample_tick = (div_reg == SAMPLE_DIV - 1);
  wire strength_sel = (sel_reg == `SEL_STRENGTH);

  // offset and slope: slope is 4.4 fixed point, offset signed
  // Product kept ten bits wider than the level so a large slope saturates instead of wrapping
  wire signed [LW+9:0] corr_prod = $signed({2'b00, adc_data, 8'h00}) * $signed({1'b0, slope_reg});
  wire signed [LW+9:0] corr_sum  = (corr_prod >>> 4) + $signed({{(LW-2){offs_reg[9]}}, offs_reg, 2'b00});
  wire [LW-1:0] corr = corr_sum[LW+9] ? {LW{1'b0}} : ((|corr_sum[LW+8:LW]) ? {LW{1'b1}} : corr_sum[LW-1:0]);

  wire rising = (corr >= level_reg);
  wire [LW-1:0] err = rising ? corr - level_reg : level_reg - corr;
  // attack while rising, decay (relative to attack) while falling
  wire [4:0] shift = rising ? {1'b0, upsh_reg} : {1'b0, upsh_reg} + {1'b0, dnsh_reg};
  wire [LW-1:0] step = err >> shift;

  // absolute thresholds in 0.1 dB with the low 7 level bits dropped
  wire [10:0] lvl_db = level_reg[LW-1:LW-11];
  wire [10:0] th_lo  = {1'b0, thoffs_reg} + {1'b0, tlo_reg};
  wire [10:0] th_up  = {1'b0, thoffs_reg} + {1'b0, tup_reg};
  // release point below threshold minus shared hysteresis
  wire [11:0] rel_lo = {1'b0, th_lo} - {2'b00, hys_reg};
  wire [11:0] rel_up = {1'b0, th_up} - {2'b00, hys_reg};
  wire below_lo = rel_lo[11] ? 1'b0 : ({1'b0, lvl_db} < rel_lo);
  wire below_up = rel_up[11] ? 1'b0 : ({1'b0, lvl_db} < rel_up);

  wire [5:0] delog_idx;
  wire [11:0] delog_rd;
  // delog index from the error magnitude
  assign delog_idx = (err[LW-1:LW-6] != 6'h00) ? 6'h3f : err[LW-7:LW-12];

  strength_delog_table #(.AW(6), .DW(12)) delog_table (
    .aclk  (aclk),
    .addr  (delog_idx),
    .rdata (delog_rd)
  );

  always @(posedge aclk) begin
    if (!aresetn)
      div_reg <= 10'h000;
    else if (sample_tick)
      div_reg <= 10'h000;
    else
      div_reg <= div_reg + 10'h001;
  end

  // timing window kept in own registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 1'b1;
      tcnt_reg   <= 16'h0000;
    end else begin
      case (tmode_reg)
        `TM_ALWAYS: active_reg <= 1'b1;
        // start at identification, run for programmed samples plus one
        `TM_START: begin
          if (signal_ident) begin
            active_reg <= 1'b1;
            tcnt_reg   <= tlen_reg;
          end else if (active_reg && sample_tick) begin
            if (tcnt_reg == 16'h0000)
              active_reg <= 1'b0;
            else
              tcnt_reg <= tcnt_reg - 16'h0001;
          end
        end
        // freeze at identification after programmed delay
        `TM_FREEZE: begin
          if (signal_ident)
            tcnt_reg <= tlen_reg;
          else if (tcnt_reg != 16'h0000 && sample_tick) begin
            tcnt_reg <= tcnt_reg - 16'h0001;
            if (tcnt_reg == 16'h0001)
              active_reg <= 1'b0;
          end
        end
        default: active_reg <= 1'b1;
      endcase
    end
  end

  // integrator advances once per sample, only on strength input
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_reg  <= {LW{1'b0}};
      cmp_lo_reg <= 1'b0;
      cmp_up_reg <= 1'b0;
    end else if (sample_tick && strength_sel && active_reg) begin
      level_reg <= rising ? level_reg + step : level_reg - step;
      if (lvl_db >= th_lo)
        cmp_lo_reg <= 1'b1;
      // back to maximum gain below low release point
      else if (below_lo)
        cmp_lo_reg <= 1'b0;
      if (lvl_db >= th_up)
        cmp_up_reg <= 1'b1;
      else if (below_up)
        cmp_up_reg <= 1'b0;
    end
  end

  // encode gain step, three values, matching correction
  always @(posedge aclk) begin
    if (!aresetn) begin
      second_if_gain          <= `GAIN_MAX;
      digital_gain_correction <= 8'h00;
      delog_value             <= 12'h000;
    end else begin
      delog_value <= delog_rd;
      if (cmp_lo_reg && cmp_up_reg) begin
        second_if_gain          <= `GAIN_MIN;
        digital_gain_correction <= dgc_min_reg;
      end else if (cmp_lo_reg) begin
        second_if_gain          <= `GAIN_MID;
        digital_gain_correction <= dgc_mid_reg;
      end else begin
        second_if_gain          <= `GAIN_MAX;
        digital_gain_correction <= 8'h00;
      end
    end
  end

  // reference warm-up in sleep with non-strength input
  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_ref_enable <= 1'b0;
      warm_reg             <= 16'h0000;
      ref_ready_reg        <= 1'b1;
    end else if (strength_sel) begin
      converter_ref_enable <= 1'b0;
      warm_reg             <= 16'h0000;
      ref_ready_reg        <= 1'b1;
    end else if (sleep_mode && !converter_ref_enable) begin
      converter_ref_enable <= 1'b1;
      warm_reg             <= STARTUP_CYC[15:0];
      ref_ready_reg        <= 1'b0;
    end else if (warm_reg != 16'h0000) begin
      warm_reg <= warm_reg - 16'h0001;
      if (warm_reg == 16'h0001)
        ref_ready_reg <= 1'b1;
    end
  end

  // AXI write channel capture, address and data in either order
  wire wr_go = aw_seen_reg && w_seen_reg && !s_axi_bvalid;
  wire rd_strb = s_axi_arvalid && s_axi_arready;
  wire eoc_clr = rd_strb && (s_axi_araddr == `A_RESH);

  // end of conversion; a new result wins over the read clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      eoc_reg    <= 1'b0;
      result_reg <= {DW{1'b0}};
    end else if (adc_done && ref_ready_reg) begin
      eoc_reg    <= 1'b1;
      result_reg <= adc_data;
    end else if (eoc_clr)
      eoc_reg <= 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_seen_reg   <= 1'b0;
      w_seen_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg <= `A_ADCSEL && awaddr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
        aw_seen_reg  <= 1'b0;
        w_seen_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes; byte strobes ignored, every field written whole from the full data word
  always @(posedge aclk) begin
    if (!aresetn) begin
      if_attenuation_setting_reg   <= 4'h0;
      ddc_reg     <= 1'b1;
      offs_reg    <= 10'h000;
      slope_reg   <= `RST_SLOPE;
      upsh_reg    <= `RST_UPSH;
      dnsh_reg    <= `RST_DNSH;
      thoffs_reg  <= `RST_THOFFS;
      tlo_reg     <= `RST_TLO;
      tup_reg     <= `RST_TUP;
      hys_reg     <= `RST_HYS;
      dgc_mid_reg <= `RST_DGC_MID;
      dgc_min_reg <= `RST_DGC_MIN;
      tmode_reg   <= `TM_ALWAYS;
      tlen_reg    <= 16'h0000;
      sel_reg     <= `SEL_STRENGTH;
    end else if (wr_go) begin
      case (awaddr_reg)
        // attenuation code, limited to 0..7 in single mode
        `A_IF_ATTENUATION_SETTING: begin
          ddc_reg   <= wdata_reg[4];
          if_attenuation_setting_reg <= (!wdata_reg[4] && wdata_reg[3]) ? 4'h7 : wdata_reg[3:0];
        end
        `A_CORR: begin
          offs_reg  <= wdata_reg[9:0];
          slope_reg <= wdata_reg[23:16];
        end
        `A_PMF: begin
          upsh_reg <= wdata_reg[3:0];
          dnsh_reg <= wdata_reg[11:8];
        end
        `A_THR: begin
          thoffs_reg <= wdata_reg[9:0];
          tlo_reg    <= wdata_reg[19:10];
          tup_reg    <= wdata_reg[29:20];
        end
        `A_HYS: hys_reg <= wdata_reg[9:0];
        `A_DGC: begin
          dgc_mid_reg <= wdata_reg[7:0];
          dgc_min_reg <= wdata_reg[15:8];
        end
        `A_TIMING: begin
          tmode_reg <= wdata_reg[17:16];
          tlen_reg  <= wdata_reg[15:0];
        end
        // input select; undefined codes fall back to strength
        `A_ADCSEL: sel_reg <= (wdata_reg[2:0] > `SEL_SUPPLY) ? `SEL_STRENGTH : wdata_reg[2:0];
        default: sel_reg <= sel_reg;
      endcase
    end
  end

  // Drive pins from registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      if_attenuation_setting <= 4'h0;
      converter_input_select <= `SEL_STRENGTH;
    end else begin
      if_attenuation_setting <= if_attenuation_setting_reg;
      converter_input_select <= sel_reg;
    end
  end

  // AXI read: one cycle after address taken, held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (rd_strb) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (s_axi_araddr)
        `A_IF_ATTENUATION_SETTING:  s_axi_rdata <= {27'h0000000, ddc_reg, if_attenuation_setting_reg};
        `A_CORR:   s_axi_rdata <= {8'h00, slope_reg, 6'h00, offs_reg};
        `A_PMF:    s_axi_rdata <= {20'h00000, dnsh_reg, 4'h0, upsh_reg};
        `A_THR:    s_axi_rdata <= {2'h0, tup_reg, tlo_reg, thoffs_reg};
        `A_HYS:    s_axi_rdata <= {22'h000000, hys_reg};
        `A_DGC:    s_axi_rdata <= {16'h0000, dgc_min_reg, dgc_mid_reg};
        `A_TIMING: s_axi_rdata <= {14'h0000, tmode_reg, tlen_reg};
        `A_ADCSEL: s_axi_rdata <= {29'h00000000, sel_reg};
        `A_STATUS: s_axi_rdata <= {26'h0000000, active_reg, ref_ready_reg, cmp_up_reg, cmp_lo_reg, second_if_gain == `GAIN_MAX, eoc_reg};
        // high byte holds the top eight result bits
        `A_RESH:   s_axi_rdata <= {24'h000000, result_reg[DW-1:DW-8]};
        `A_RESL:   s_axi_rdata <= {30'h00000000, result_reg[1:0]};
        `A_LEVEL:  s_axi_rdata <= {{(32-LW){1'b0}}, level_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // rssi_agc_and_adc_mux

// [dv/agc_port_chk.sv]
// Port-level assertions for the signal-strength gain control block
`timescale 1ns/1ps
`include "agc_defs.vh"
module agc_port_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       sleep_mode,
  input wire logic [1:0] second_if_gain,
  input wire logic [7:0] digital_gain_correction,
  input wire logic [2:0] converter_input_select,
  input wire logic       converter_ref_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the gain step last moved; saturates so the first move after reset is allowed
  logic [1:0] gain_prev_reg;
  logic [9:0] since_reg;
  always @(posedge aclk) begin
    gain_prev_reg <= second_if_gain;
    if (!aresetn) since_reg <= 10'h3ff;
    else if (second_if_gain != gain_prev_reg) since_reg <= 10'h000;
    else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
  end

  property p_gain_legal; second_if_gain != 2'h3; endproperty
  a_gain_legal: assert property (p_gain_legal)
    else $error("gain step took the unused code");
  property p_dgc_max; second_if_gain == `GAIN_MAX |-> digital_gain_correction == 8'h00; endproperty
  a_dgc_max: assert property (p_dgc_max)
    else $error("digital correction not zero at maximum gain");
  property p_gain_tick; second_if_gain != gain_prev_reg |-> since_reg >= 10'h2bc; endproperty
  a_gain_tick: assert property (p_gain_tick)
    else $error("gain step moved between sample ticks");
  property p_sel_legal; converter_input_select <= `SEL_SUPPLY; endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("converter select holds an undefined code");
  property p_ref_on;
    (sleep_mode && converter_input_select != `SEL_STRENGTH) [*2] |-> converter_ref_enable;
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("references off in sleep with auxiliary input");
  property p_ref_off; (converter_input_select == `SEL_STRENGTH) [*2] |-> !converter_ref_enable; endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("references on while strength is selected");
  property p_b_after_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_after_w: assert property (p_b_after_w)
    else $error("write response late");
  property p_r_after_ar; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_r_after_ar: assert property (p_r_after_ar)
    else $error("read data late");

  // Main scenarios reached
  c_gain_min: cover property (second_if_gain == `GAIN_MIN);
  c_gain_mid: cover property (second_if_gain == `GAIN_MID);
  c_ref_on: cover property ($rose(converter_ref_enable));
endmodule // agc_port_chk

bind rssi_agc_and_adc_mux agc_port_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .sleep_mode(sleep_mode), .second_if_gain(second_if_gain), .digital_gain_correction(digital_gain_correction),
  .converter_input_select(converter_input_select), .converter_ref_enable(converter_ref_enable)
);

// [dv/conv_model.sv]
// Behavioural signal-strength converter feeding samples and end-of-conversion pulses
`timescale 1ns/1ps
module conv_model #(
  parameter int REFRESH = 200
) (
  input  wire logic [0:0] aclk,
  input  wire logic [9:0] level_in,
  output logic      [9:0] adc_data,
  output logic            adc_done
);
  int cnt_reg;

  initial begin
    cnt_reg = 0;
    adc_data = 10'h000;
    adc_done = 1'b0;
  end

  // free-running conversions at a fixed rate; done is a one-cycle pulse
  always @(posedge aclk) begin
    cnt_reg <= (cnt_reg == REFRESH - 1) ? 0 : cnt_reg + 1;
    adc_done <= (cnt_reg == REFRESH - 1);
    adc_data <= level_in;
  end
endmodule // conv_model

// [dv/testbench.sv]
// Self-checking bench for the signal-strength gain control block
`timescale 1ns/1ps
`include "agc_defs.vh"
module testbench;
  localparam int TICK = 729;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, adc_done, sleep_mode, signal_ident, converter_ref_enable;
  logic [7:0]  awaddr, araddr, digital_gain_correction;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, second_if_gain;
  logic [9:0]  adc_data, level;
  logic [3:0]  if_attenuation_setting;
  logic [11:0] delog_value;
  logic [2:0]  converter_input_select;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;

  // Clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Short start-up so the reference wait fits the run
  rssi_agc_and_adc_mux #(.STARTUP_CYC(20)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .adc_data(adc_data), .adc_done(adc_done),
    .sleep_mode(sleep_mode), .signal_ident(signal_ident), .if_attenuation_setting(if_attenuation_setting),
    .second_if_gain(second_if_gain), .digital_gain_correction(digital_gain_correction),
    .converter_input_select(converter_input_select), .converter_ref_enable(converter_ref_enable),
    .delog_value(delog_value)
  );

  conv_model #(.REFRESH(200)) conv_u (.aclk(aclk), .level_in(level), .adc_data(adc_data), .adc_done(adc_done));

  task automatic conclude;
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, exp);
  endtask

  task automatic wo(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask

  task automatic gchk(input logic [1:0] g, input logic [7:0] c);
    chk({22'h0, second_if_gain, digital_gain_correction}, {22'h0, g, c});
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge aclk);
  endtask

  function automatic logic [31:0] thr(input logic [9:0] o, input logic [9:0] l, input logic [9:0] u);
    return {2'h0, u, l, o};
  endfunction

  task automatic pulse_ident;
    @(posedge aclk);
    signal_ident <= 1'b1;
    @(posedge aclk);
    signal_ident <= 1'b0;
  endtask

  // Reset values: 63.9, 12.8, 25.6 and 21.3 dB in tenths
  task automatic t_defaults;
    rc(8'h00, 32'h10, 32'h1f);
    rc(8'h04, 32'h100000, 32'hff03ff);
    rc(8'h08, 32'h404, 32'hf0f);
    rc(8'h0c, thr(10'h27f, 10'h080, 10'h100), 32'h3fffffff);
    rc(8'h10, 32'h0d5, 32'h3ff);
    rc(8'h1c, 32'h0, 32'h7);
    gchk(`GAIN_MAX, 8'h00);
  endtask

  // Write to a read-only register and read of an unmapped place are refused
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h24, 32'h1, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    rd(8'h30, d, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    chk(d, 32'h0);
  endtask

  task automatic t_atten;
    logic [4:0] wv [4] = '{5'h1f, 5'h0f, 5'h05, 5'h10};
    logic [3:0] ev [4] = '{4'hf, 4'h7, 4'h5, 4'h0};
    for (int i = 0; i < 4; i++) begin
      wo(8'h00, {27'h0, wv[i]});
      repeat (2) @(posedge aclk);
      chk({28'h0, if_attenuation_setting}, {28'h0, ev[i]});
    end
  endtask

  task automatic t_mux;
    logic [2:0] wv [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    logic [2:0] ev [4] = '{3'h0, 3'h1, 3'h2, 3'h0};
    int n;
    for (int i = 0; i < 4; i++) begin
      wo(8'h1c, {29'h0, wv[i]});
      repeat (2) @(posedge aclk);
      chk({29'h0, converter_input_select}, {29'h0, ev[i]});
    end
    wo(8'h1c, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, converter_ref_enable}, 32'h0);
    sleep_mode <= 1'b1;
    level <= 10'h2b7;
    repeat (3) @(posedge aclk);
    chk({31'h0, converter_ref_enable}, 32'h1);
    rc(8'h20, 32'h00, 32'h10);
    repeat (25) @(posedge aclk);
    rc(8'h20, 32'h10, 32'h10);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!adc_done && n < 400);
    repeat (2) @(posedge aclk);
    rc(8'h20, 32'h11, 32'h11);
    rc(8'h24, 32'had, 32'hff);
    rc(8'h20, 32'h00, 32'h01);
    // Next result read only after a full converter refresh period
    repeat (740) @(posedge aclk);
    rc(8'h24, 32'had, 32'hff);
    wo(8'h1c, 32'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, converter_ref_enable}, 32'h0);
    sleep_mode <= 1'b0;
  endtask

  // Unit coefficients settle the integrator in one tick; reconfigure with the input deselected
  task automatic t_gain;
    logic [11:0] d0;
    wo(8'h08, 32'h0);
    wo(8'h0c, 32'h0);
    wo(8'h10, 32'h0);
    wo(8'h14, 32'ha53c);
    level <= 10'h3ff;
    ticks(3);
    gchk(`GAIN_MIN, 8'ha5);
    level <= 10'h000;
    wo(8'h0c, thr(10'h000, 10'h000, 10'h020));
    ticks(3);
    gchk(`GAIN_MID, 8'h3c);
    wo(8'h1c, 32'h1);
    // Integrator frozen while deselected, so a held input step keeps the error large
    d0 = delog_value;
    level <= 10'h3ff;
    repeat (5) @(posedge aclk);
    chk({31'h0, delog_value > d0}, 32'h1);
    level <= 10'h000;
    wo(8'h10, 32'h10);
    wo(8'h0c, thr(10'h010, 10'h000, 10'h020));
    wo(8'h1c, 32'h0);
    ticks(3);
    gchk(`GAIN_MID, 8'h3c);
    wo(8'h10, 32'h0f);
    ticks(3);
    gchk(`GAIN_MAX, 8'h00);
  endtask

  task automatic t_timing;
    wo(8'h18, {14'h0, `TM_START, 16'h1});
    // First tick closes the idle start window before zero thresholds could trip
    ticks(1);
    wo(8'h0c, 32'h0);
    wo(8'h10, 32'h0);
    level <= 10'h3ff;
    ticks(3);
    gchk(`GAIN_MAX, 8'h00);
    pulse_ident();
    ticks(3);
    gchk(`GAIN_MIN, 8'ha5);
    wo(8'h18, 32'h0);
    wo(8'h18, {14'h0, `TM_FREEZE, 16'h1});
    pulse_ident();
    ticks(2);
    level <= 10'h000;
    wo(8'h0c, thr(10'h010, 10'h000, 10'h000));
    wo(8'h10, 32'h0f);
    ticks(3);
    gchk(`GAIN_MIN, 8'ha5);
    wo(8'h18, 32'h0);
    ticks(3);
    gchk(`GAIN_MAX, 8'h00);
    wo(8'h08, 32'h404);
  endtask

  // Hang guard well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    sleep_mode = 1'b0;
    signal_ident = 1'b0;
    level = 10'h000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_unmapped();
    t_atten();
    t_mux();
    t_gain();
    t_timing();
    conclude();
  end
endmodule // testbench
